// ### rtl/slscf_regs.svh
// constants for the spi-compatible serial link framer
// Functional notes
// (RULE1) data launched on clock rising edge, captured on falling edge
// (RULE2) only sixteen-bit words are carried
// (RULE3) second transmit line is an active-low select, low for the whole frame
// (RULE4) receiver has no select input and ignores its second data line
// (RULE5) receiver shifts one bit from first data line on every active clock edge
// (RULE6) no preamble or postamble clocks are sent
// (RULE7) after the frame, transmit clock and data lines return to idle levels
// (RULE8) every frame phase is sent except preamble and postamble
// (RULE9) receiver checks data and frame errors just as in normal mode
// (RULE10) far party builds and parses complete frames with every checked field
// (RULE11) transmitter is always the clock source, never clocked from outside
// (RULE12) ping watchdog, tag filtering and user crc remain usable
// (RULE13) receive clock and data pass programmable delay lines up to 31 elements
// (RULE14) receive clock is asynchronous and crosses into the system domain safely
// (RULE15) crc, start and end patterns and tags inserted on send, checked on receipt
// (RULE16) select falls before first rising edge and rises after last falling edge
`ifndef SLSCF_REGS_SVH
`define SLSCF_REGS_SVH
`define SLSCF_WORD_BITS   16
`define SLSCF_SOF         4'hD
`define SLSCF_EOF         4'h6
`define SLSCF_TYPE_DATA   4'h2
`define SLSCF_TYPE_PING   4'h9
`define SLSCF_CRC_POLY    8'h07
`define SLSCF_CRC_SEED    8'hFF
`define SLSCF_DLY_MAX     31
`define SLSCF_SOF_BITS    4
`define SLSCF_TYPE_BITS   4
`define SLSCF_TAG_BITS    4
`define SLSCF_CRC_BITS    8
`define SLSCF_EOF_BITS    4
`define SLSCF_PING_WD_DEF 100000
`endif

// ### rtl/slscf_pkg.sv
// types for the spi-compatible serial link framer
package slscf_pkg;
  typedef enum logic [3:0] {
    SLSCF_TX_IDLE = 4'b0001,
    SLSCF_TX_LEAD = 4'b0010,
    SLSCF_TX_BIT  = 4'b0100,
    SLSCF_TX_TAIL = 4'b1000
  } slscf_tx_st_t;
  typedef enum logic [1:0] {
    SLSCF_RX_HUNT = 2'b01,
    SLSCF_RX_BODY = 2'b10
  } slscf_rx_st_t;
  typedef struct packed {
    logic [3:0] ftype;
    logic [3:0] tag;
    logic       user_crc_en;
    logic [7:0] user_crc;
  } slscf_tx_hdr_t;
  typedef struct packed {
    logic valid;
    logic ping;
    logic crc_err;
    logic frame_err;
    logic tag_miss;
  } slscf_rx_evt_t;
endpackage

// ### rtl/slscf_top.sv
// spi-compatible serial link framer: transmitter and receiver
`timescale 1ns/1ps
`include "slscf_regs.svh"
module slscf_top import slscf_pkg::*; #(
  parameter int          WORDS         = 1,
  parameter int          HALF_DIV      = 2,
  parameter int unsigned PING_WD_LIMIT = `SLSCF_PING_WD_DEF
) (
  input  wire logic                       CLK,
  input  wire logic                       RST_N,
  input  wire logic                       CE,
  input  wire logic                       TX_START,
  input  wire slscf_tx_hdr_t              TX_HDR,
  input  wire logic [WORDS*16-1:0]        TX_DATA,
  output logic                            TX_READY,
  output logic                            TX_SERIAL_CLOCK_PIN,
  output logic                            TX_FIRST_DATA_LINE,
  output logic                            TX_SECOND_DATA_LINE,
  input  wire logic                       RX_SERIAL_CLOCK_PIN,
  input  wire logic                       RX_FIRST_DATA_LINE,
  input  wire logic                       RX_SECOND_DATA_LINE,
  input  wire logic [4:0]                 RX_CLOCK_DELAY_SETTING,
  input  wire logic [4:0]                 RX_FIRST_DATA_DELAY_SETTING,
  input  wire logic [4:0]                 RX_SECOND_DATA_DELAY_SETTING,
  input  wire logic [3:0]                 RX_TAG_REF,
  input  wire logic [3:0]                 RX_TAG_MASK,
  input  wire logic                       RX_PING_WD_EN,
  output logic [WORDS*16-1:0]             RX_DATA,
  output logic [3:0]                      RX_TAG,
  output slscf_rx_evt_t                   RX_EVENT,
  output logic                            RX_PING_TIMEOUT
);
  localparam int PAY_BITS   = `SLSCF_TYPE_BITS + WORDS*`SLSCF_WORD_BITS + `SLSCF_TAG_BITS;
  localparam int BODY_BITS  = PAY_BITS + `SLSCF_CRC_BITS + `SLSCF_EOF_BITS;
  localparam int FRAME_BITS = `SLSCF_SOF_BITS + BODY_BITS;
  localparam int DW         = WORDS*`SLSCF_WORD_BITS;

  function automatic logic [7:0] crc_calc(input logic [PAY_BITS-1:0] pay);
    logic [7:0] c;
    c = `SLSCF_CRC_SEED;
    for (int i = PAY_BITS-1; i >= 0; i--) begin
      c = (c[7] ^ pay[i]) ? ({c[6:0], 1'b0} ^ `SLSCF_CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_ff;
  logic rst_n_ff;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // transmitter: clock source, select on second line
  slscf_tx_st_t              tx_st_ff,  nxt_tx_st;
  logic [FRAME_BITS-1:0]     tx_sh_ff,  nxt_tx_sh;
  logic [15:0]               tx_cnt_ff, nxt_tx_cnt;
  logic [15:0]               div_ff,    nxt_div;
  logic                      clk_o_ff,  nxt_clk_o;
  logic                      d0_ff,     nxt_d0;
  logic                      cs_n_ff,   nxt_cs_n;
  logic [7:0]                tx_crc;
  logic [PAY_BITS-1:0]       tx_pay;
  logic                      div_done;

  assign tx_pay   = {TX_HDR.ftype, TX_DATA, TX_HDR.tag};
  assign tx_crc   = TX_HDR.user_crc_en ? TX_HDR.user_crc : crc_calc(tx_pay); // [RULE12] [RULE15]
  assign div_done = (div_ff == 16'(HALF_DIV-1));
  assign TX_READY = (tx_st_ff == SLSCF_TX_IDLE);

  always_comb begin
    nxt_tx_st  = tx_st_ff;
    nxt_tx_sh  = tx_sh_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_div    = div_done ? 16'h0000 : div_ff + 16'h0001;
    nxt_clk_o  = clk_o_ff;
    nxt_d0     = d0_ff;
    nxt_cs_n   = cs_n_ff;
    case (tx_st_ff)
      SLSCF_TX_IDLE: begin
        nxt_div = 16'h0000;
        if (TX_START) begin
          // full frame, no preamble or postamble clocks [RULE6] [RULE8] [RULE15]
          nxt_tx_sh  = {`SLSCF_SOF, tx_pay, tx_crc, `SLSCF_EOF};
          nxt_cs_n   = 1'b0; // [RULE3] [RULE16]
          nxt_tx_cnt = 16'h0000;
          nxt_tx_st  = SLSCF_TX_LEAD;
        end
      end
      SLSCF_TX_LEAD: begin
        if (div_done) begin
          nxt_clk_o = 1'b1; // [RULE1] [RULE11]
          nxt_d0    = tx_sh_ff[FRAME_BITS-1];
          nxt_tx_sh = {tx_sh_ff[FRAME_BITS-2:0], 1'b0};
          nxt_tx_st = SLSCF_TX_BIT;
        end
      end
      SLSCF_TX_BIT: begin
        if (div_done) begin
          if (clk_o_ff) begin
            nxt_clk_o = 1'b0;
          end else if (tx_cnt_ff == 16'(FRAME_BITS-1)) begin
            nxt_tx_st = SLSCF_TX_TAIL;
          end else begin
            nxt_clk_o  = 1'b1; // [RULE1]
            nxt_d0     = tx_sh_ff[FRAME_BITS-1];
            nxt_tx_sh  = {tx_sh_ff[FRAME_BITS-2:0], 1'b0};
            nxt_tx_cnt = tx_cnt_ff + 16'h0001;
          end
        end
      end
      SLSCF_TX_TAIL: begin
        if (div_done) begin
          nxt_cs_n  = 1'b1; // [RULE16] [RULE3]
          nxt_d0    = 1'b0; // [RULE7]
          nxt_clk_o = 1'b0;
          nxt_tx_st = SLSCF_TX_IDLE;
        end
      end
      default: begin
        nxt_tx_st = SLSCF_TX_IDLE;
        nxt_clk_o = 1'b0;
        nxt_d0    = 1'b0;
        nxt_cs_n  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tx_st_ff  <= SLSCF_TX_IDLE;
      tx_sh_ff  <= '0;
      tx_cnt_ff <= 16'h0000;
      div_ff    <= 16'h0000;
      clk_o_ff  <= 1'b0;
      d0_ff     <= 1'b0;
      cs_n_ff   <= 1'b1;
    end else if (CE) begin
      tx_st_ff  <= nxt_tx_st;
      tx_sh_ff  <= nxt_tx_sh;
      tx_cnt_ff <= nxt_tx_cnt;
      div_ff    <= nxt_div;
      clk_o_ff  <= nxt_clk_o;
      d0_ff     <= nxt_d0;
      cs_n_ff   <= nxt_cs_n;
    end
  end

  assign TX_SERIAL_CLOCK_PIN = clk_o_ff;
  assign TX_FIRST_DATA_LINE  = d0_ff;
  assign TX_SECOND_DATA_LINE = cs_n_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // receive pin synchronisers and delay lines (lane 0 clock, 1 data0, 2 data1)
  logic [2:0]      sync1_ff, sync2_ff;
  logic [2:0][4:0] dly_set;
  logic [2:0][`SLSCF_DLY_MAX:0] chain;
  logic [2:0]      dly_out;
  assign dly_set = {RX_SECOND_DATA_DELAY_SETTING, RX_FIRST_DATA_DELAY_SETTING,
                    RX_CLOCK_DELAY_SETTING};

  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
    end else if (CE) begin
      sync1_ff <= {RX_SECOND_DATA_LINE, RX_FIRST_DATA_LINE, RX_SERIAL_CLOCK_PIN}; // [RULE14]
      sync2_ff <= sync1_ff;
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_dly
    logic [`SLSCF_DLY_MAX:1] dly_ff;
    assign chain[g] = {dly_ff, sync2_ff[g]};
    always_ff @(posedge CLK or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
        dly_ff <= '0;
      end else if (CE) begin
        dly_ff <= chain[g][`SLSCF_DLY_MAX-1:0];
      end
    end
    assign dly_out[g] = chain[g][dly_set[g]]; // [RULE13]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive frame logic, shifting on the falling edge of the link clock
  slscf_rx_st_t            rx_st_ff,   nxt_rx_st;
  logic                    rclk_ff;
  logic [3:0]              win_ff,     nxt_win;
  logic [BODY_BITS-1:0]    rx_sh_ff,   nxt_rx_sh;
  logic [15:0]             rx_cnt_ff,  nxt_rx_cnt;
  logic [DW-1:0]           rx_data_ff, nxt_rx_data;
  logic [3:0]              rx_tag_ff,  nxt_rx_tag;
  slscf_rx_evt_t           evt_ff,     nxt_evt;
  logic [31:0]             wd_ff,      nxt_wd;
  logic                    wd_to_ff,   nxt_wd_to;
  logic                    rx_fall;
  logic                    rbit;
  logic [BODY_BITS-1:0]    body;
  logic [PAY_BITS-1:0]     rx_pay;
  logic [3:0]              b_type, b_tag, b_eof;
  logic [7:0]              b_crc;

  assign rx_fall = rclk_ff & ~dly_out[0]; // [RULE1] [RULE5]
  assign rbit    = dly_out[1];            // second data lane never read [RULE4]
  assign body    = {rx_sh_ff[BODY_BITS-2:0], rbit};
  assign rx_pay  = body[BODY_BITS-1 -: PAY_BITS];
  assign b_type  = body[BODY_BITS-1 -: 4];
  assign b_tag   = body[12 +: 4];
  assign b_crc   = body[4 +: 8];
  assign b_eof   = body[3:0];

  always_comb begin
    nxt_rx_st   = rx_st_ff;
    nxt_win     = win_ff;
    nxt_rx_sh   = rx_sh_ff;
    nxt_rx_cnt  = rx_cnt_ff;
    nxt_rx_data = rx_data_ff;
    nxt_rx_tag  = rx_tag_ff;
    nxt_evt     = '0;
    nxt_wd      = (RX_PING_WD_EN && wd_ff != PING_WD_LIMIT-1) ?
                  wd_ff + 32'h0000_0001 : 32'h0000_0000;
    nxt_wd_to   = RX_PING_WD_EN && (wd_ff == PING_WD_LIMIT-1); // [RULE12]
    if (rx_fall) begin
      nxt_win = {win_ff[2:0], rbit}; // [RULE5]
      case (rx_st_ff)
        SLSCF_RX_HUNT: begin
          if ({win_ff[2:0], rbit} == `SLSCF_SOF) begin // [RULE15]
            nxt_rx_st  = SLSCF_RX_BODY;
            nxt_rx_cnt = 16'h0000;
          end
        end
        SLSCF_RX_BODY: begin
          nxt_rx_sh  = body;
          nxt_rx_cnt = rx_cnt_ff + 16'h0001;
          if (rx_cnt_ff == 16'(BODY_BITS-1)) begin
            nxt_rx_st = SLSCF_RX_HUNT;
            nxt_win   = 4'h0;
            if (b_eof != `SLSCF_EOF ||
                (b_type != `SLSCF_TYPE_DATA && b_type != `SLSCF_TYPE_PING)) begin
              nxt_evt.frame_err = 1'b1; // [RULE9] [RULE15]
            end else if (b_crc != crc_calc(rx_pay)) begin
              nxt_evt.crc_err = 1'b1; // [RULE9] [RULE15]
            end else if (((b_tag ^ RX_TAG_REF) & RX_TAG_MASK) != 4'h0) begin
              nxt_evt.tag_miss = 1'b1; // [RULE12]
            end else if (b_type == `SLSCF_TYPE_PING) begin
              nxt_evt.ping = 1'b1;
              nxt_rx_tag   = b_tag;
              nxt_wd       = 32'h0000_0000; // [RULE12]
              nxt_wd_to    = 1'b0;
            end else begin
              nxt_evt.valid = 1'b1;
              nxt_rx_tag    = b_tag;
              nxt_rx_data   = body[16 +: DW]; // [RULE2]
            end
          end
        end
        default: begin
          nxt_rx_st = SLSCF_RX_HUNT;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rx_st_ff   <= SLSCF_RX_HUNT;
      rclk_ff    <= 1'b0;
      win_ff     <= 4'h0;
      rx_sh_ff   <= '0;
      rx_cnt_ff  <= 16'h0000;
      rx_data_ff <= '0;
      rx_tag_ff  <= 4'h0;
      evt_ff     <= '0;
      wd_ff      <= 32'h0000_0000;
      wd_to_ff   <= 1'b0;
    end else if (CE) begin
      rx_st_ff   <= nxt_rx_st;
      rclk_ff    <= dly_out[0];
      win_ff     <= nxt_win;
      rx_sh_ff   <= nxt_rx_sh;
      rx_cnt_ff  <= nxt_rx_cnt;
      rx_data_ff <= nxt_rx_data;
      rx_tag_ff  <= nxt_rx_tag;
      evt_ff     <= nxt_evt;
      wd_ff      <= nxt_wd;
      wd_to_ff   <= nxt_wd_to;
    end
  end

  assign RX_DATA         = rx_data_ff;
  assign RX_TAG          = rx_tag_ff;
  assign RX_EVENT        = evt_ff;
  assign RX_PING_TIMEOUT = wd_to_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  logic [15:0] rise_cnt_ff;
  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rise_cnt_ff <= 16'h0000;
    end else if (CE) begin
      if (tx_st_ff == SLSCF_TX_IDLE) begin
        rise_cnt_ff <= 16'h0000;
      end else if (nxt_clk_o && !clk_o_ff) begin
        rise_cnt_ff <= rise_cnt_ff + 16'h0001;
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n_ff);

  a_cs_frame_low: assert property (tx_st_ff != SLSCF_TX_IDLE && $past(tx_st_ff) != SLSCF_TX_IDLE
    |-> !TX_SECOND_DATA_LINE) else $error("select high inside frame"); // [RULE3]
  a_idle_levels: assert property (tx_st_ff == SLSCF_TX_IDLE |-> !TX_SERIAL_CLOCK_PIN
    && !TX_FIRST_DATA_LINE && TX_SECOND_DATA_LINE) else $error("lines not idle"); // [RULE7]
  a_clk_in_frame: assert property ($rose(TX_SERIAL_CLOCK_PIN) |-> tx_st_ff == SLSCF_TX_BIT
    && $past(tx_st_ff) != SLSCF_TX_IDLE) else $error("clock outside frame"); // [RULE6]
  a_cs_before_clk: assert property ($rose(TX_SERIAL_CLOCK_PIN) |-> $past(!TX_SECOND_DATA_LINE))
    else $error("clock before select"); // [RULE16]
  a_data_on_rise: assert property ($changed(TX_FIRST_DATA_LINE) && tx_st_ff != SLSCF_TX_IDLE
    |-> $rose(TX_SERIAL_CLOCK_PIN)) else $error("data not launched on rise"); // [RULE1]
  a_frame_length: assert property ($rose(TX_SECOND_DATA_LINE) |-> $past(rise_cnt_ff)
    == 16'(FRAME_BITS)) else $error("wrong bit count per frame"); // [RULE8]
  a_rx_shift: assert property (rx_fall && CE && rx_st_ff == SLSCF_RX_BODY
    && rx_cnt_ff != 16'(BODY_BITS-1) |=> rx_cnt_ff == $past(rx_cnt_ff) + 16'h0001)
    else $error("receive bit not shifted"); // [RULE5]
  a_rx_evt_edge: assert property (evt_ff != '0 && $past(CE) |-> $past(rx_fall)
    && $past(rx_st_ff) == SLSCF_RX_BODY) else $error("event without edge"); // [RULE9]
  a_wd_timeout: assert property (RX_PING_TIMEOUT && $past(CE) |-> $past(wd_ff)
    == PING_WD_LIMIT-1) else $error("watchdog fired early"); // [RULE12]
endmodule // slscf_top

// ### bench/slscf_spi_peer.sv
// external spi-style controller: captures sent frames and drives received frames
`timescale 1ns/1ps
module slscf_spi_peer (
  input  wire logic tx_clk,
  input  wire logic tx_data,
  input  wire logic tx_sel_n,
  output logic      rx_clk,
  output logic      rx_data,
  output logic      rx_unused
);
  logic [39:0] cap_bits;
  int          cap_count;
  int          frames_seen;
  int          edge_faults;
  initial begin
    rx_clk = 1'b0;
    rx_data = 1'b0;
    rx_unused = 1'b0;
    cap_bits = '0;
    cap_count = 0;
    frames_seen = 0;
    edge_faults = 0;
  end
  // capture on the falling clock edge while selected
  always @(negedge tx_clk) begin
    if (tx_sel_n === 1'b0) begin
      cap_bits = {cap_bits[38:0], tx_data};
      cap_count++;
    end
  end
  // clocks outside the select window are preamble or postamble
  always @(posedge tx_clk) begin
    if (tx_sel_n !== 1'b0) edge_faults++;
  end
  // select moves only while the clock is low
  always @(negedge tx_sel_n) begin
    cap_count = 0;
    if ($time > 0 && tx_clk !== 1'b0) edge_faults++;
  end
  always @(posedge tx_sel_n) begin
    frames_seen++;
    if ($time > 0 && tx_clk !== 1'b0) edge_faults++;
  end
  // whole frame supplied by the caller, launched on rising edges, clock still between frames
  task automatic send_frame(input logic [39:0] bits);
    for (int i = 39; i >= 0; i--) begin
      #400 rx_clk = 1'b1;
      rx_data = bits[i];
      rx_unused = ~rx_unused;
      #400 rx_clk = 1'b0;
    end
    fork
      #300 rx_data = ~rx_data;
    join_none
  endtask
endmodule // slscf_spi_peer

// ### bench/serial_link_spi_compat_framer_test.sv
// self-checking bench for the spi-compatible serial link framer
`timescale 1ns/1ps
`include "slscf_regs.svh"
module serial_link_spi_compat_framer_test;
  import slscf_pkg::*;
  logic          clk, rst_n, ce, tx_start, tx_ready, tx_sck, tx_d0, tx_d1_n;
  logic          rx_sck, rx_d0, rx_d1, wd_en, ping_to;
  slscf_tx_hdr_t hdr;
  slscf_rx_evt_t evt;
  logic [15:0]   tx_data, rx_data, last_data;
  logic [4:0]    dly_clk, dly_d0, dly_d1;
  logic [3:0]    tag_ref, tag_mask, rx_tag, last_tag;
  int            n_errors, comparisons;

  slscf_top #(.WORDS(1), .HALF_DIV(2), .PING_WD_LIMIT(50)) dut (
    .CLK(clk), .RST_N(rst_n), .CE(ce), .TX_START(tx_start), .TX_HDR(hdr),
    .TX_DATA(tx_data), .TX_READY(tx_ready), .TX_SERIAL_CLOCK_PIN(tx_sck),
    .TX_FIRST_DATA_LINE(tx_d0), .TX_SECOND_DATA_LINE(tx_d1_n),
    .RX_SERIAL_CLOCK_PIN(rx_sck), .RX_FIRST_DATA_LINE(rx_d0), .RX_SECOND_DATA_LINE(rx_d1),
    .RX_CLOCK_DELAY_SETTING(dly_clk), .RX_FIRST_DATA_DELAY_SETTING(dly_d0),
    .RX_SECOND_DATA_DELAY_SETTING(dly_d1), .RX_TAG_REF(tag_ref), .RX_TAG_MASK(tag_mask),
    .RX_PING_WD_EN(wd_en), .RX_DATA(rx_data), .RX_TAG(rx_tag), .RX_EVENT(evt),
    .RX_PING_TIMEOUT(ping_to));
  slscf_spi_peer peer (.tx_clk(tx_sck), .tx_data(tx_d0), .tx_sel_n(tx_d1_n),
    .rx_clk(rx_sck), .rx_data(rx_d0), .rx_unused(rx_d1));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic tally_and_finish;
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic hang(input string msg);
    n_errors++;
    $display("BAD %0t %s", $time, msg);
    tally_and_finish();
  endtask
  function automatic logic [7:0] crc8(input logic [23:0] msg);
    logic [7:0] c;
    c = `SLSCF_CRC_SEED;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ msg[i]) ? `SLSCF_CRC_POLY : 8'h00);
    return c;
  endfunction
  function automatic logic [39:0] frame(input logic [3:0] ft, input logic [15:0] d,
                                        input logic [3:0] tg, input logic [7:0] c);
    return {`SLSCF_SOF, ft, d, tg, c, `SLSCF_EOF};
  endfunction

  task automatic tx_case(input slscf_tx_hdr_t h, input logic [15:0] d);
    logic [7:0] c;
    int         seen;
    seen = peer.frames_seen;
    c = h.user_crc_en ? h.user_crc : crc8({h.ftype, d, h.tag});
    check(tx_ready === 1'b1, "transmitter not ready");
    hdr = h;
    tx_data = d;
    tx_start = 1'b1;
    @(negedge clk);
    tx_start = 1'b0;
    check(tx_ready === 1'b0 && tx_d1_n === 1'b0 && tx_sck === 1'b0,
          "select not low");
    for (int i = 0; i < 400 && peer.frames_seen == seen; i++) @(negedge clk);
    if (peer.frames_seen == seen) hang("frame never ended");
    check(peer.cap_count == 40, "sent bit count");
    check(peer.cap_bits === frame(h.ftype, d, h.tag, c), "sent frame content");
    check(tx_sck === 1'b0 && tx_d0 === 1'b0 && tx_ready === 1'b1, "idle levels");
  endtask

  task automatic rx_case(input int kind);
    logic [15:0]   d;
    logic [3:0]    tg, ft;
    logic [39:0]   f;
    slscf_rx_evt_t exp, e;
    time           t0;
    d = 16'($urandom);
    tg = (kind >= 4) ? ~tag_ref : tag_ref;
    ft = (kind == 1) ? `SLSCF_TYPE_PING : `SLSCF_TYPE_DATA;
    tag_mask = (kind == 5) ? 4'h0 : 4'hf;
    f = frame(ft, d, tg, crc8({ft, d, tg}));
    if (kind == 2) f[4] = ~f[4];
    if (kind == 3) f[3:0] = ~f[3:0];
    exp = (kind == 5) ? 5'b10000 : 5'(5'b10000 >> kind);
    if (exp.valid) last_data = d;
    if (exp.valid || exp.ping) last_tag = tg;
    peer.send_frame(f);
    t0 = $time;
    e = '0;
    for (int i = 0; i < 80 && e == '0; i++) begin
      @(negedge clk);
      e = evt;
    end
    if (e == '0) hang("no receive event");
    check(e === exp, "receive event kind");
    check($time - t0 == 64'(300 + 100 * dly_clk), "receive latency");
    check(rx_data === last_data && rx_tag === last_tag, "receive data or tag");
    @(negedge clk);
    check(evt === '0, "event pulse too long");
  endtask

  initial begin : main
    slscf_tx_hdr_t h;
    n_errors = 0;
    comparisons = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    tx_start = 1'b0;
    hdr = '0;
    tx_data = '0;
    wd_en = 1'b0;
    dly_clk = '0;
    dly_d0 = '0;
    dly_d1 = '0;
    tag_ref = 4'h5;
    tag_mask = 4'hf;
    last_data = '0;
    last_tag = '0;
    void'($urandom(43));
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    check(tx_d1_n === 1'b1 && tx_sck === 1'b0 && evt === '0, "reset levels");
    repeat (3) @(negedge clk);
    for (int i = 0; i < 6; i++) begin
      h.ftype = (i % 2) ? `SLSCF_TYPE_PING : `SLSCF_TYPE_DATA;
      h.tag = 4'($urandom);
      h.user_crc_en = (i >= 4);
      h.user_crc = 8'($urandom);
      tx_case(h, (i == 0) ? 16'hffff : 16'($urandom));
    end
    check(peer.edge_faults == 0, "clock outside select");
    for (int i = 0; i < 12; i++) begin
      repeat (40) @(negedge clk);
      dly_clk = (i == 11) ? 5'h1f : 5'($urandom);
      dly_d0 = dly_clk;
      dly_d1 = 5'($urandom);
      tag_ref = 4'($urandom);
      rx_case(i % 6);
    end
    h.ftype = `SLSCF_TYPE_DATA;
    h.user_crc_en = 1'b0;
    fork
      tx_case(h, 16'h0000);
      rx_case(0);
    join
    ce = 1'b0;
    wd_en = 1'b1;
    for (int i = 0; i < 80; i++) begin
      @(negedge clk);
      check(ping_to === 1'b0, "watchdog ran while frozen");
    end
    ce = 1'b1;
    for (int i = 0; i < 70 && ping_to !== 1'b1; i++) @(negedge clk);
    check(ping_to === 1'b1, "ping watchdog silent");
    wd_en = 1'b0;
    for (int i = 0; i < 120; i++) begin
      @(negedge clk);
      if (ping_to !== 1'b0) hang("watchdog fired while off");
    end
    check(peer.edge_faults == 0, "clock outside select");
    tally_and_finish();
  end
endmodule // serial_link_spi_compat_framer_test
